//--- bench/host_processor_bus_slave_port_tb.sv
// Testbench joining both host port ends and judging their user sides.
`timescale 1ns/1ps
module host_processor_bus_slave_port_tb
    import hps_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cmd_valid_i, cmd_write_i, cmd_burst_i;
    logic sys_done_i = 1'b0;
    logic sys_error_i = 1'b0;
    logic sys_busy_i = 1'b0;
    logic cmd_ready_o, rsp_valid_o, rsp_error_o, rsp_retry_o;
    logic sys_req_o, sys_write_o, parity_error_o;
    logic [3:0] cmd_beats_i;
    logic [1:0] cmd_size_i, width_sel_i, sys_size_o;
    logic [ADDR_W-1:0] cmd_addr_i, sys_addr_o;
    logic [DATA_W-1:0] cmd_wdata_i, rsp_rdata_o, sys_wdata_o;
    logic [DATA_W-1:0] sys_rdata_i = '0;
    logic [DATA_W-1:0] wdata_seen;
    logic [1:0] size_seen;
    logic write_seen;
    hps_end_e mode;
    int failures = 0;
    int checked = 0;
    int delay = 0;
    int wait_cnt = 0;
    int perr = 0;
    always #5 clk_i = ~clk_i;
    hps_link_if link (.clk_i, .reset_n_i);
    hps_master i_hps_master (.link, .cmd_valid_i, .cmd_ready_o, .cmd_write_i,
        .cmd_burst_i, .cmd_beats_i, .cmd_addr_i, .cmd_size_i, .cmd_wdata_i,
        .rsp_valid_o, .rsp_rdata_o, .rsp_error_o, .rsp_retry_o);
    hps_port i_hps_port (.link, .sys_req_o, .sys_write_o, .sys_addr_o,
        .sys_size_o, .sys_wdata_o, .sys_done_i, .sys_error_i, .sys_busy_i,
        .sys_rdata_i, .width_sel_i, .parity_error_o);
    hps_link_chk i_hps_link_chk (.clk_i, .reset_n_i,
        .strobe_n(link.strobe_n), .write_n(link.write_n),
        .burst_indicator_n(link.burst_indicator_n),
        .transfer_size(link.transfer_size),
        .transfer_acknowledge_n(link.transfer_acknowledge_n),
        .transfer_error_ack_n(link.transfer_error_ack_n),
        .retry_request_n(link.retry_request_n),
        .dev_data_oe(link.dev_data_oe), .data_bus(link.data_bus),
        .par_bus(link.par_bus));
    ////////////////////////////////////////////////////////////
    // Internal bus stand-in; read data encodes the address seen.
    always @(posedge clk_i) begin
        sys_done_i <= 1'b0;
        sys_error_i <= 1'b0;
        sys_busy_i <= 1'b0;
        if (parity_error_o === 1'b1) begin
            perr <= perr + 1;
        end
        if (sys_req_o === 1'b1 && !(sys_done_i | sys_error_i | sys_busy_i))
        begin
            if (wait_cnt < delay) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                sys_done_i <= mode == HPS_END_ACK;
                sys_error_i <= mode == HPS_END_ERR;
                sys_busy_i <= mode == HPS_END_RETRY;
                sys_rdata_i <= 32'ha5000000 | DATA_W'(sys_addr_o);
                wdata_seen <= sys_wdata_o;
                size_seen <= sys_size_o;
                write_seen <= sys_write_o;
            end
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic wr, bst, input logic [3:0] beats,
        input logic [ADDR_W-1:0] addr, input logic [1:0] size,
        input hps_end_e m);
        int n;
        int got;
        int exp;
        logic [DATA_W-1:0] base;
        n = 0;
        got = 0;
        // A burst length of zero or above the limit runs the full limit.
        exp = (bst && m == HPS_END_ACK) ? ((beats == 4'h0 ||
            beats > BURST_BEATS) ? int'(BURST_BEATS) : int'(beats)) : 1;
        base = DATA_W'(addr);
        mode = m;
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_burst_i <= bst;
        cmd_beats_i <= beats;
        cmd_addr_i <= addr;
        cmd_size_i <= size;
        cmd_wdata_i <= 32'h5a000000 | base;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        while (link.strobe_n !== 1'b0 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        if (link.strobe_n !== 1'b0) begin
            chk("strobe_timeout", 1, 0);
            report_and_stop();
        end
        chk("address", link.host_address, addr);
        chk("size", link.transfer_size, size);
        chk("burst", link.burst_indicator_n, !bst);
        chk("write", link.write_n, !wr);
        n = 0;
        while (!(got >= exp && cmd_ready_o === 1'b1) && n < 200) begin
            @(posedge clk_i);
            n++;
            if (rsp_valid_o === 1'b1) begin
                chk("error", rsp_error_o, m == HPS_END_ERR);
                chk("retry", rsp_retry_o, m == HPS_END_RETRY);
                if (!wr && m == HPS_END_ACK && width_sel_i == WIDTH_32) begin
                    chk("rdata", rsp_rdata_o, 32'ha5000000 + base + 4 * got);
                end
                got++;
            end
        end
        if (!(got >= exp && cmd_ready_o === 1'b1)) begin
            chk("timeout", 1, 0);
            report_and_stop();
        end
        chk("beats", got, exp);
        chk("sys_write", write_seen, wr);
        chk("sys_size", size_seen, size);
        if (wr && m == HPS_END_ACK && width_sel_i == WIDTH_32) begin
            chk("wdata", wdata_seen, 32'h5a000000 | base);
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic test_sizes();
        logic [1:0] sz [3] = '{TSIZE_BYTE, TSIZE_HALF, TSIZE_WORD};
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 1'b0, 4'h1, 18'h00100, sz[i], HPS_END_ACK);
            xfer(1'b0, 1'b0, 4'h1, 18'h3fffc, sz[i], HPS_END_ACK);
        end
    endtask
    // Slow answers keep the master waiting between burst beats.
    task automatic test_bursts();
        delay = 3;
        xfer(1'b0, 1'b1, 4'h4, 18'h01000, TSIZE_WORD, HPS_END_ACK);
        xfer(1'b0, 1'b1, 4'h2, 18'h02000, TSIZE_WORD, HPS_END_ACK);
        xfer(1'b1, 1'b1, 4'h4, 18'h03000, TSIZE_WORD, HPS_END_ACK);
        xfer(1'b0, 1'b1, 4'h7, 18'h04000, TSIZE_WORD, HPS_END_ACK);
        xfer(1'b1, 1'b1, 4'h0, 18'h05000, TSIZE_WORD, HPS_END_ACK);
        delay = 0;
    endtask
    task automatic test_faults();
        xfer(1'b0, 1'b0, 4'h1, 18'h00040, TSIZE_WORD, HPS_END_ERR);
        xfer(1'b1, 1'b0, 4'h1, 18'h00044, TSIZE_HALF, HPS_END_RETRY);
        xfer(1'b0, 1'b1, 4'h4, 18'h00080, TSIZE_WORD, HPS_END_ERR);
        xfer(1'b1, 1'b1, 4'h4, 18'h000c0, TSIZE_WORD, HPS_END_RETRY);
    endtask
    task automatic test_widths();
        width_sel_i <= WIDTH_8;
        xfer(1'b1, 1'b0, 4'h1, 18'h00200, TSIZE_BYTE, HPS_END_ACK);
        xfer(1'b0, 1'b0, 4'h1, 18'h00201, TSIZE_BYTE, HPS_END_ACK);
        width_sel_i <= WIDTH_16;
        xfer(1'b1, 1'b0, 4'h1, 18'h00202, TSIZE_HALF, HPS_END_ACK);
        width_sel_i <= WIDTH_32;
        chk("parity_error", perr, 0);
    endtask
    initial begin
        {cmd_valid_i, cmd_write_i, cmd_burst_i, cmd_beats_i, cmd_addr_i} = '0;
        {cmd_size_i, cmd_wdata_i} = '0;
        width_sel_i = WIDTH_32;
        mode = HPS_END_ACK;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        test_sizes();
        test_bursts();
        test_faults();
        test_widths();
        report_and_stop();
    end
endmodule

//--- bench/hps_link_chk.sv
// Protocol checker for the link between the master and port ends.
`timescale 1ns/1ps
module hps_link_chk
    import hps_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Master side.
    input wire logic strobe_n,
    input wire logic write_n,
    input wire logic burst_indicator_n,
    input wire logic [1:0] transfer_size,
    // Port side.
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_error_ack_n,
    input wire logic retry_request_n,
    input wire logic dev_data_oe,
    input wire logic [DATA_W-1:0] data_bus,
    input wire logic [PAR_W-1:0] par_bus
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic term_any;
    logic lane0_ok;
    assign term_any = !(transfer_acknowledge_n & transfer_error_ack_n
        & retry_request_n);
    // Lane 0 is active at every width, so it alone is safe to judge.
    assign lane0_ok = par_bus[0] == ~(^data_bus[7:0]);
    ////////////////////////////////////////////////////////////
    a_one_termination: assert property (
        $onehot0({~transfer_acknowledge_n, ~transfer_error_ack_n,
        ~retry_request_n})) else $error("two terminations at once");
    a_ack_pulse: assert property (
        !transfer_acknowledge_n |=> transfer_acknowledge_n)
        else $error("acknowledge held longer than one cycle");
    a_term_after_strobe: assert property (
        $fell(strobe_n) |-> ##[2:40] term_any)
        else $error("transfer never terminated");
    a_no_early_term: assert property (
        !strobe_n |-> !term_any ##1 !term_any)
        else $error("termination before the wait state");
    a_read_drive: assert property (
        dev_data_oe |-> write_n && !transfer_acknowledge_n)
        else $error("port drove data outside a read acknowledge");
    a_read_ack_oe: assert property (
        !transfer_acknowledge_n && write_n |-> dev_data_oe)
        else $error("read acknowledged without data");
    a_lane_parity: assert property (
        dev_data_oe || (!strobe_n && !write_n) |-> lane0_ok)
        else $error("lane parity wrong");
    a_burst_word: assert property (
        !strobe_n && !burst_indicator_n |-> transfer_size == TSIZE_WORD)
        else $error("burst with non-word size");
    c_burst: cover property (!strobe_n && !burst_indicator_n);
    c_error: cover property (!transfer_error_ack_n);
    c_retry: cover property (!retry_request_n);
endmodule

//--- logic/hps_link_if.sv
// Pin-level link between the host bus master and the device host port.
`timescale 1ns/1ps
interface hps_link_if
    import hps_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i
);
    logic [ADDR_W-1:0] host_address;
    logic strobe_n;
    logic write_n;
    logic burst_indicator_n;
    logic burst_continue_request_n;
    logic [1:0] transfer_size;
    logic transfer_acknowledge_n;
    logic transfer_error_ack_n;
    logic retry_request_n;
    logic [DATA_W-1:0] mst_data;
    logic [DATA_W-1:0] dev_data;
    logic [PAR_W-1:0] mst_par;
    logic [PAR_W-1:0] dev_par;
    logic mst_data_oe;
    logic dev_data_oe;
    // An undriven bus reads as zero, so no stale word is ever taken.
    wire [DATA_W-1:0] data_bus = dev_data_oe ? dev_data :
        (mst_data_oe ? mst_data : '0);
    wire [PAR_W-1:0] par_bus = dev_data_oe ? dev_par :
        (mst_data_oe ? mst_par : '0);

    modport master (
        input clk_i, reset_n_i, transfer_acknowledge_n, transfer_error_ack_n,
        input retry_request_n, data_bus, par_bus,
        output host_address, strobe_n, write_n, burst_indicator_n,
        output burst_continue_request_n, transfer_size, mst_data, mst_par,
        output mst_data_oe
    );
    modport port (
        input clk_i, reset_n_i, host_address, strobe_n, write_n,
        input burst_indicator_n, burst_continue_request_n, transfer_size,
        input data_bus, par_bus,
        output transfer_acknowledge_n, transfer_error_ack_n, retry_request_n,
        output dev_data, dev_par, dev_data_oe
    );
endinterface

//--- logic/hps_master.sv
// Master end: drives host port transfers from a simple user command port.
`timescale 1ns/1ps
module hps_master
    import hps_pkg::*;
(
    hps_link_if.master link,
    // User command.
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic cmd_burst_i,
    input wire logic [3:0] cmd_beats_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [1:0] cmd_size_i,
    input wire logic [DATA_W-1:0] cmd_wdata_i,
    // User answer, one pulse per beat.
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    output logic rsp_error_o,
    output logic rsp_retry_o
);
    typedef enum logic {MS_IDLE, MS_BUSY} hps_ms_e;

    hps_ms_e state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic write_q, write_d;
    logic burst_q, burst_d;
    logic [1:0] size_q, size_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [3:0] left_q, left_d;
    logic strb_q, strb_d;
    logic valid_q, valid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic rty_q, rty_d;
    logic term;

    assign term = !link.transfer_acknowledge_n || !link.transfer_error_ack_n
        || !link.retry_request_n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        write_d = write_q;
        burst_d = burst_q;
        size_d = size_q;
        wdata_d = wdata_q;
        left_d = left_q;
        strb_d = 1'b0;
        valid_d = 1'b0;
        rdata_d = rdata_q;
        err_d = 1'b0;
        rty_d = 1'b0;
        unique case (state_q)
            MS_IDLE: begin
                if (cmd_valid_i) begin
                    addr_d = cmd_addr_i;
                    write_d = cmd_write_i;
                    burst_d = cmd_burst_i;
                    size_d = cmd_burst_i ? TSIZE_WORD : cmd_size_i;
                    wdata_d = cmd_wdata_i;
                    left_d = cmd_burst_i ? ((cmd_beats_i > BURST_BEATS ||
                        cmd_beats_i == 4'h0) ? BURST_BEATS : cmd_beats_i)
                        : 4'h1;
                    strb_d = 1'b1;
                    state_d = MS_BUSY;
                end
            end
            MS_BUSY: begin
                if (term) begin
                    valid_d = 1'b1;
                    rdata_d = link.data_bus;
                    err_d = !link.transfer_error_ack_n;
                    rty_d = !link.retry_request_n;
                    left_d = left_q - 4'h1;
                    if (!link.transfer_acknowledge_n && left_q > 4'h1) begin
                        addr_d = addr_q + ADDR_W'(DATA_W / 8);
                    end else begin
                        state_d = MS_IDLE;
                    end
                end
            end
            default: state_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge link.clk_i or negedge link.reset_n_i) begin
        if (!link.reset_n_i) begin
            state_q <= MS_IDLE;
            addr_q <= '0;
            write_q <= 1'b0;
            burst_q <= 1'b0;
            size_q <= TSIZE_WORD;
            wdata_q <= DATA_RST;
            left_q <= 4'h0;
            strb_q <= 1'b0;
            valid_q <= 1'b0;
            rdata_q <= DATA_RST;
            err_q <= 1'b0;
            rty_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            write_q <= write_d;
            burst_q <= burst_d;
            size_q <= size_d;
            wdata_q <= wdata_d;
            left_q <= left_d;
            strb_q <= strb_d;
            valid_q <= valid_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            rty_q <= rty_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign cmd_ready_o = state_q == MS_IDLE;
    assign link.host_address = addr_q;
    assign link.strobe_n = !strb_q;
    assign link.write_n = !write_q;
    assign link.burst_indicator_n = !(burst_q && state_q == MS_BUSY);
    // Keep asking for beats while more than the current one remain.
    assign link.burst_continue_request_n =
        !(burst_q && state_q == MS_BUSY && left_q > 4'h1);
    assign link.transfer_size = size_q;
    assign link.mst_data = wdata_q;
    assign link.mst_par = hps_parity(wdata_q);
    assign link.mst_data_oe = state_q == MS_BUSY && write_q;
    assign rsp_valid_o = valid_q;
    assign rsp_rdata_o = rdata_q;
    assign rsp_error_o = err_q;
    assign rsp_retry_o = rty_q;
endmodule

//--- logic/hps_pkg.sv
// Shared constants and types for the host port link and both of its ends.
package hps_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int LANE_W = 8;
    localparam logic [1:0] TSIZE_WORD = 2'h0;
    localparam logic [1:0] TSIZE_BYTE = 2'h1;
    localparam logic [1:0] TSIZE_HALF = 2'h2;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [3:0] BURST_BEATS = 4'h4;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0;
    typedef enum logic [1:0] {
        HPS_END_ACK,
        HPS_END_ERR,
        HPS_END_RETRY
    } hps_end_e;

    // Lane mask for the active data width, used by the port end.
    function automatic logic [PAR_W-1:0] hps_lanes(input logic [1:0] width);
        unique case (width)
            WIDTH_8: hps_lanes = 4'h1;
            WIDTH_16: hps_lanes = 4'h3;
            default: hps_lanes = 4'hf;
        endcase
    endfunction

    // Odd parity per byte lane; bit n covers data bits 8n..8n+7.
    function automatic logic [PAR_W-1:0] hps_parity(
        input logic [DATA_W-1:0] data
    );
        for (int i = 0; i < PAR_W; i++) begin
            hps_parity[i] = ~(^data[i*LANE_W +: LANE_W]);
        end
    endfunction
endpackage

//--- logic/hps_port.sv
// Device end: host port slave bridging the master to the internal system bus.
`timescale 1ns/1ps
module hps_port
    import hps_pkg::*;
(
    hps_link_if.port link,
    // Internal system bus request.
    output logic sys_req_o,
    output logic sys_write_o,
    output logic [ADDR_W-1:0] sys_addr_o,
    output logic [1:0] sys_size_o,
    output logic [DATA_W-1:0] sys_wdata_o,
    // Internal system bus answer.
    input wire logic sys_done_i,
    input wire logic sys_error_i,
    input wire logic sys_busy_i,
    input wire logic [DATA_W-1:0] sys_rdata_i,
    // Configuration and status.
    input wire logic [1:0] width_sel_i,
    output logic parity_error_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TERM} hps_st_e;

    hps_st_e state_q, state_d;
    hps_end_e end_q, end_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic write_q, write_d;
    logic burst_q, burst_d;
    logic [1:0] size_q, size_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [PAR_W-1:0] rpar_q, rpar_d;
    logic perr_q, perr_d;
    logic [PAR_W-1:0] lanes;
    logic take_req;
    logic next_beat;
    logic sys_answer;
    logic read_ack;

    // True when an active lane of a master word carries bad parity.
    // Inactive lanes are ignored, since a narrow master leaves them floating.
    function automatic logic lane_fault(
        input logic [PAR_W-1:0] active,
        input logic [DATA_W-1:0] data,
        input logic [PAR_W-1:0] par
    );
        lane_fault = |(active & (hps_parity(data) ^ par));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign lanes = hps_lanes(width_sel_i);
    // A new transfer is only taken in idle; strobes while busy are ignored.
    assign take_req = state_q == ST_IDLE && !link.strobe_n;
    // Burst beats continue while the master asks for more.
    assign next_beat = state_q == ST_TERM && end_q == HPS_END_ACK &&
        burst_q && !link.burst_continue_request_n;
    assign sys_answer = sys_error_i || sys_busy_i || sys_done_i;
    assign read_ack = state_q == ST_TERM && end_q == HPS_END_ACK &&
        !write_q;

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencing and the end code of each beat.
    always_comb begin
        state_d = state_q;
        end_d = end_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take_req) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (sys_answer) begin
                    state_d = ST_TERM;
                end
                // Error outranks retry, retry outranks a normal finish.
                if (sys_error_i) begin
                    end_d = HPS_END_ERR;
                end else if (sys_busy_i) begin
                    end_d = HPS_END_RETRY;
                end else if (sys_done_i) begin
                    end_d = HPS_END_ACK;
                end
            end
            ST_TERM: begin
                if (next_beat) begin
                    state_d = ST_WAIT;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge link.clk_i or negedge link.reset_n_i) begin
        if (!link.reset_n_i) begin
            state_q <= ST_IDLE;
            end_q <= HPS_END_ACK;
        end else begin
            state_q <= state_d;
            end_q <= end_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request capture. Write data is taken at the strobe and again at each
    // continued beat, because the master may change it between beats.
    always_comb begin
        addr_d = addr_q;
        write_d = write_q;
        burst_d = burst_q;
        size_d = size_q;
        wdata_d = wdata_q;
        if (take_req) begin
            addr_d = link.host_address;
            write_d = !link.write_n;
            burst_d = !link.burst_indicator_n;
            size_d = link.transfer_size;
            wdata_d = link.data_bus;
        end else if (next_beat) begin
            addr_d = addr_q + ADDR_W'(DATA_W / 8);
            wdata_d = link.data_bus;
        end
    end

    always_ff @(posedge link.clk_i or negedge link.reset_n_i) begin
        if (!link.reset_n_i) begin
            addr_q <= '0;
            write_q <= 1'b0;
            burst_q <= 1'b0;
            size_q <= TSIZE_WORD;
            wdata_q <= DATA_RST;
        end else begin
            addr_q <= addr_d;
            write_q <= write_d;
            burst_q <= burst_d;
            size_q <= size_d;
            wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read return. Parity is made here so the pins come from flip-flops.
    always_comb begin
        rdata_d = rdata_q;
        rpar_d = rpar_q;
        if (state_q == ST_WAIT && sys_done_i && !sys_error_i &&
            !sys_busy_i) begin
            rdata_d = sys_rdata_i;
            rpar_d = hps_parity(sys_rdata_i);
        end
    end

    always_ff @(posedge link.clk_i or negedge link.reset_n_i) begin
        if (!link.reset_n_i) begin
            rdata_q <= DATA_RST;
            rpar_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            rpar_q <= rpar_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write parity check. A bad lane is only reported; the transfer still
    // completes, so software decides what a corrupted word means.
    always_comb begin
        perr_d = 1'b0;
        if (take_req) begin
            perr_d = !link.write_n &&
                lane_fault(lanes, link.data_bus, link.par_bus);
        end else if (next_beat) begin
            perr_d = write_q &&
                lane_fault(lanes, link.data_bus, link.par_bus);
        end
    end

    always_ff @(posedge link.clk_i or negedge link.reset_n_i) begin
        if (!link.reset_n_i) begin
            perr_q <= 1'b0;
        end else begin
            perr_q <= perr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal system bus request, held for the whole wait state.
    assign sys_req_o = state_q == ST_WAIT;
    assign sys_write_o = write_q;
    assign sys_addr_o = addr_q;
    assign sys_size_o = size_q;
    assign sys_wdata_o = wdata_q;
    assign parity_error_o = perr_q;

    // One termination strobe per beat, from the registered end code.
    assign link.transfer_acknowledge_n =
        !(state_q == ST_TERM && end_q == HPS_END_ACK);
    assign link.transfer_error_ack_n =
        !(state_q == ST_TERM && end_q == HPS_END_ERR);
    assign link.retry_request_n =
        !(state_q == ST_TERM && end_q == HPS_END_RETRY);
    // Data goes out only beside a read acknowledge; on an error or retry
    // the master must not take a word that no one fetched.
    assign link.dev_data_oe = read_ack;
    assign link.dev_data = rdata_q;
    assign link.dev_par = rpar_q & lanes;
endmodule
